/* File: logic/adc_output_if_power_config.sv */
`timescale 1ns/1ps
// Contract
// - Three-bit bit-map codes one to six select the six output bit mappings.
// - A new bit-map value takes effect only on a fuse reload command.
// - Fuse reload discards serial writes, returning registers to loaded values.
// - After reset fused bit-map applies, yet the field reads zero until written.
// - Mode selection overrides the fused mode only while override bit three is set.
// - Mode codes: single 0, double 1, two-wire 3, one-wire 4, half-wire 5.
// - After reset fused mode applies while the mode field reads zero.
// - Power bit 5 set powers down the sampling clock buffer.
// - Power bit 4 set powers down the reference gain amplifier.
// - Power bit 3 set enables the temperature sensor; clear at reset.
// - Power bit 2 set powers down converter channel A.
// - Power bit 0 invokes global power-down on blocks chosen by the mask register.
// - Writing one to register zero bit 0 restores defaults, then self clears.
module adc_output_if_power_config (
    input  wire logic          SYS_CLK,
    input  wire logic          RESET_N,
    input  wire logic          SCLK,
    input  wire logic          SEN_N,
    input  wire logic          SDI,
    output logic               SDOUT,
    output logic               SDOUT_OE,
    output cfg_pkg::bit_map_t  IF_BIT_MAP,
    output cfg_pkg::if_mode_t  IF_MODE,
    output logic               CLKBUF_OFF,
    output logic               REFAMP_OFF,
    output logic               REFSYS_OFF,
    output logic               BANDGAP_OFF,
    output logic               THERMAL_ON,
    output logic               CHANNEL_A_OFF
);
    import cfg_pkg::*;

    logic [1:0]        rst_sync_q;
    logic              rst_n;
    logic [DATA_W-1:0] if_sel_q;
    logic [DATA_W-1:0] power_q;
    logic [DATA_W-1:0] mask_q;
    logic              soft_q;
    bit_map_t          map_eff_q;
    logic              seen_wr_q;

    reg_bus_if bus ();

    // The reset is released through two flops so every flop leaves reset on the same edge.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    serial_port u_serial_port (
        .clk      (SYS_CLK),
        .rst_n    (rst_n),
        .sclk     (SCLK),
        .sen_n    (SEN_N),
        .sdi      (SDI),
        .sdout    (SDOUT),
        .sdout_oe (SDOUT_OE),
        .bus      (bus.master)
    );

    // Write decode and the fields that steer the outputs.
    wire      wr_soft     = bus.wr_stb && (bus.addr == OFF_SOFT_RESET) && bus.wdata[POS_SOFT_RESET];
    wire      wr_if_sel   = bus.wr_stb && (bus.addr == OFF_IF_SEL);
    wire      wr_power    = bus.wr_stb && (bus.addr == OFF_POWER);
    wire      wr_mask     = bus.wr_stb && (bus.addr == OFF_PD_MASK);
    wire      fuse_stb    = bus.wr_stb && (bus.addr == OFF_FUSE_LOAD) && bus.wdata[POS_FUSE_LOAD];
    wire      restore     = soft_q || fuse_stb;
    wire [2:0] map_field  = field3(if_sel_q, POS_MAP_LSB);
    wire [2:0] mode_field = field3(if_sel_q, POS_MODE_LSB);
    wire      override_en = if_sel_q[POS_OVR_EN];
    wire      global_pd   = power_q[POS_GLOBAL_PD];

    // Unmapped offsets, the fuse load register and the soft reset bit read as zero once settled.
    assign bus.rdata = (bus.addr == OFF_SOFT_RESET) ? {7'h00, soft_q} :
                       (bus.addr == OFF_IF_SEL)     ? if_sel_q :
                       (bus.addr == OFF_POWER)      ? power_q :
                       (bus.addr == OFF_PD_MASK)    ? mask_q : 8'h00;

    // Register file; a restore outranks a write landing in the same cycle.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            if_sel_q <= RST_IF_SEL;
            power_q  <= RST_POWER;
            mask_q   <= RST_PD_MASK;
        end else if (restore) begin
            if_sel_q <= RST_IF_SEL;
            power_q  <= RST_POWER;
            mask_q   <= RST_PD_MASK;
        end else begin
            if (wr_if_sel) begin
                if_sel_q <= bus.wdata & WMASK_IF_SEL;
            end
            if (wr_power) begin
                power_q <= (bus.wdata & WMASK_POWER) | RST_POWER;
            end
            if (wr_mask) begin
                mask_q <= bus.wdata & WMASK_PD_MASK;
            end
        end
    end

    // The soft reset bit shows one for a single cycle, then clears itself.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= wr_soft;
        end
    end

    // The bit mapping is sampled only at a fuse load, since the datapath cannot retime mid-stream.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            map_eff_q <= FUSE_BIT_MAP;
        end else if (fuse_stb) begin
            map_eff_q <= (map_field == MAP_NONE) ? FUSE_BIT_MAP : bit_map_t'(map_field);
        end
    end

    // Output flops; the global power-down only reaches blocks whose mask bit is set.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            IF_BIT_MAP    <= FUSE_BIT_MAP;
            IF_MODE       <= FUSE_MODE;
            CLKBUF_OFF    <= 1'b0;
            REFAMP_OFF    <= 1'b0;
            REFSYS_OFF    <= 1'b0;
            BANDGAP_OFF   <= 1'b0;
            THERMAL_ON    <= 1'b0;
            CHANNEL_A_OFF <= 1'b0;
        end else begin
            IF_BIT_MAP    <= map_eff_q;
            IF_MODE       <= override_en ? if_mode_t'(mode_field) : FUSE_MODE;
            CLKBUF_OFF    <= power_q[POS_CLKBUF_OFF] | (global_pd & mask_q[POS_MASK_CLKBUF]);
            REFAMP_OFF    <= power_q[POS_REFAMP_OFF] | (global_pd & mask_q[POS_MASK_REFAMP]);
            REFSYS_OFF    <= global_pd & mask_q[POS_MASK_REFSYS];
            BANDGAP_OFF   <= global_pd & mask_q[POS_MASK_BANDGAP];
            THERMAL_ON    <= power_q[POS_THERMAL_ON];
            CHANNEL_A_OFF <= power_q[POS_CHAN_A_OFF];
        end
    end

    // Helper for the checks: whether the interface register has been written since defaults.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            seen_wr_q <= 1'b0;
        end else if (restore) begin
            seen_wr_q <= 1'b0;
        end else if (wr_if_sel) begin
            seen_wr_q <= 1'b1;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    sequence soft_write_s;
        wr_soft;
    endsequence

    sequence defaults_back_s;
        !soft_q && (if_sel_q == RST_IF_SEL) && (power_q == RST_POWER) && (mask_q == RST_PD_MASK);
    endsequence

    a_soft_reset_selfclear: assert property (soft_write_s |=> soft_q ##1 defaults_back_s)
        else $error("soft reset did not restore defaults and clear itself");

    a_fuse_discards_writes: assert property (fuse_stb |=> (if_sel_q == RST_IF_SEL) && (power_q == RST_POWER))
        else $error("fuse reload left serial writes in place");

    // The mapping reaches the pins two cycles after the reload, so three quiet cycles are needed here.
    a_map_needs_fuse: assert property (!fuse_stb ##1 !fuse_stb ##1 !fuse_stb |-> IF_BIT_MAP == $past(IF_BIT_MAP))
        else $error("bit mapping changed without a fuse reload");

    a_map_from_field: assert property (fuse_stb && (map_field != 3'h0) |-> ##2 IF_BIT_MAP == $past(map_field, 2))
        else $error("fuse reload did not apply the written bit mapping");

    a_unwritten_reads_zero: assert property (!seen_wr_q |-> (map_field == 3'h0) && (mode_field == 3'h0))
        else $error("interface fields read nonzero before any write");

    a_mode_override: assert property (override_en && $stable(if_sel_q) |=> IF_MODE == $past(mode_field))
        else $error("mode override not applied");

    a_mode_fused: assert property (!override_en |=> IF_MODE == FUSE_MODE)
        else $error("fused mode lost while override is off");

    a_power_bits_direct: assert property (!global_pd && $stable(power_q) |=>
        (CLKBUF_OFF == $past(power_q[POS_CLKBUF_OFF])) && (REFAMP_OFF == $past(power_q[POS_REFAMP_OFF])) &&
        (THERMAL_ON == $past(power_q[POS_THERMAL_ON])) && (CHANNEL_A_OFF == $past(power_q[POS_CHAN_A_OFF])))
        else $error("power control bits not reflected on outputs");

    a_global_masked: assert property (!global_pd ##1 !global_pd |-> !REFSYS_OFF && !BANDGAP_OFF)
        else $error("masked block powered down without global power-down");

    a_global_clkbuf: assert property (global_pd && mask_q[POS_MASK_CLKBUF] && $stable(power_q) |=> CLKBUF_OFF)
        else $error("global power-down missed the clock buffer");

    a_reserved_clear: assert property ((power_q[7:6] == 2'b00) && power_q[1] && !if_sel_q[POS_RSVD_IF])
        else $error("reserved bits hold a wrong value");

    // Masked blocks follow the global power-down one cycle later, whatever their own bits say.
    sequence global_refamp_s;
        global_pd && mask_q[POS_MASK_REFAMP];
    endsequence

    sequence global_deep_s;
        global_pd && mask_q[POS_MASK_REFSYS] && mask_q[POS_MASK_BANDGAP];
    endsequence

    a_global_refamp: assert property (global_refamp_s |=> REFAMP_OFF)
        else $error("global power-down missed the reference amplifier");

    a_global_deep_blocks: assert property (global_deep_s |=> REFSYS_OFF && BANDGAP_OFF)
        else $error("global power-down missed the reference system or bandgap");

    // The sensor has no mask bit, so a global power-down must leave it alone.
    a_thermal_unmasked: assert property (global_pd |=> THERMAL_ON == $past(power_q[POS_THERMAL_ON]))
        else $error("temperature sensor followed the global power-down");

endmodule : adc_output_if_power_config

/* File: logic/cfg_pkg.sv */
package cfg_pkg;

    // Serial frame: one read flag, seven address bits, eight data bits, MSB first.
    localparam int ADDR_W          = 7;
    localparam int DATA_W          = 8;
    localparam int CNT_W           = 5;
    localparam logic [CNT_W-1:0] FRAME_HDR_LAST  = 5'h07;
    localparam logic [CNT_W-1:0] FRAME_HDR_BITS  = 5'h08;
    localparam logic [CNT_W-1:0] FRAME_LAST      = 5'h0F;
    localparam logic [CNT_W-1:0] FRAME_BITS      = 5'h10;

    // Register offsets.
    localparam logic [ADDR_W-1:0] OFF_SOFT_RESET = 7'h00;
    localparam logic [ADDR_W-1:0] OFF_IF_SEL     = 7'h07;
    localparam logic [ADDR_W-1:0] OFF_POWER      = 7'h08;
    localparam logic [ADDR_W-1:0] OFF_PD_MASK    = 7'h0D;
    localparam logic [ADDR_W-1:0] OFF_FUSE_LOAD  = 7'h13;

    // Field positions.
    localparam int POS_SOFT_RESET   = 0;
    localparam int POS_FUSE_LOAD    = 0;
    localparam int POS_MAP_LSB      = 5;
    localparam int POS_RSVD_IF      = 4;
    localparam int POS_OVR_EN       = 3;
    localparam int POS_MODE_LSB     = 0;
    localparam int POS_CLKBUF_OFF   = 5;
    localparam int POS_REFAMP_OFF   = 4;
    localparam int POS_THERMAL_ON   = 3;
    localparam int POS_CHAN_A_OFF   = 2;
    localparam int POS_GLOBAL_PD    = 0;
    localparam int POS_MASK_REFSYS  = 5;
    localparam int POS_MASK_CLKBUF  = 3;
    localparam int POS_MASK_REFAMP  = 2;
    localparam int POS_MASK_BANDGAP = 1;

    // Reset values and writable bit masks.
    localparam logic [DATA_W-1:0] RST_IF_SEL    = 8'h00;
    localparam logic [DATA_W-1:0] RST_POWER     = 8'h02;
    localparam logic [DATA_W-1:0] RST_PD_MASK   = 8'h00;
    localparam logic [DATA_W-1:0] WMASK_IF_SEL  = 8'hEF;
    localparam logic [DATA_W-1:0] WMASK_POWER   = 8'h3F;
    localparam logic [DATA_W-1:0] WMASK_PD_MASK = 8'h2E;

    // Output bit-mapping variants.
    typedef enum logic [2:0] {
        MAP_NONE     = 3'h0,
        MAP_TWO_W_18 = 3'h1,
        MAP_TWO_W_16 = 3'h2,
        MAP_ONE_W    = 3'h3,
        MAP_HALF_W   = 3'h4,
        MAP_DOUBLE   = 3'h5,
        MAP_SINGLE   = 3'h6
    } bit_map_t;

    // Output interface modes; codes 2, 6 and 7 are unused.
    typedef enum logic [2:0] {
        MODE_SINGLE  = 3'h0,
        MODE_DOUBLE  = 3'h1,
        MODE_TWO_W   = 3'h3,
        MODE_ONE_W   = 3'h4,
        MODE_HALF_W  = 3'h5
    } if_mode_t;

    // Fused defaults stand in for the one-time-programmed cells.
    localparam bit_map_t FUSE_BIT_MAP = MAP_SINGLE;
    localparam if_mode_t FUSE_MODE    = MODE_SINGLE;

    // Extracts a three-bit field from a register byte.
    function automatic logic [2:0] field3(input logic [DATA_W-1:0] value, input int lsb);
        field3 = value[lsb +: 3];
    endfunction : field3

endpackage : cfg_pkg

/* File: logic/reg_bus_if.sv */
`timescale 1ns/1ps
interface reg_bus_if;
    import cfg_pkg::*;

    logic              wr_stb;
    logic              rd_stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;

    modport master (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport slave  (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : reg_bus_if

/* File: logic/serial_port.sv */
`timescale 1ns/1ps
module serial_port (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic sclk,
    input  wire logic sen_n,
    input  wire logic sdi,
    output logic      sdout,
    output logic      sdout_oe,
    reg_bus_if.master bus
);
    import cfg_pkg::*;

    logic             sclk_q;
    logic [CNT_W-1:0] cnt_q;
    logic [6:0]       sh_q;
    logic             read_q;
    logic [DATA_W-1:0] out_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic             wr_q;
    logic             rd_q;
    logic             sdout_q;
    logic             oe_q;

    // Edges of the serial clock; the pins are already in this clock's domain.
    wire rise      = sclk & ~sclk_q & ~sen_n;
    wire fall      = ~sclk & sclk_q & ~sen_n;
    wire hdr_done  = rise && (cnt_q == FRAME_HDR_LAST);
    wire data_done = rise && (cnt_q == FRAME_LAST) && !read_q;
    wire out_phase = read_q && (cnt_q >= FRAME_HDR_BITS) && (cnt_q < FRAME_BITS);

    // Shift in on rising edges; a deselect restarts the frame at any point.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            cnt_q  <= '0;
            sh_q   <= '0;
            read_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
            if (sen_n) begin
                cnt_q  <= '0;
                read_q <= 1'b0;
            end else if (rise) begin
                sh_q <= {sh_q[5:0], sdi};
                if (cnt_q != FRAME_BITS) begin
                    cnt_q <= cnt_q + 5'h01;
                end
                if (hdr_done) begin
                    read_q <= sh_q[6];
                end
            end
        end
    end

    // Address and write data are latched whole, then strobed for one cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q  <= '0;
            wdata_q <= '0;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
        end else begin
            wr_q <= data_done;
            rd_q <= hdr_done && sh_q[6];
            if (hdr_done) begin
                addr_q <= {sh_q[5:0], sdi};
            end
            if (data_done) begin
                wdata_q <= {sh_q[6:0], sdi};
            end
        end
    end

    // Read data leaves on falling edges so the host can sample it on the next rise.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q   <= '0;
            sdout_q <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            if (rd_q) begin
                out_q <= bus.rdata;
            end else if (fall && out_phase) begin
                sdout_q <= out_q[7];
                out_q   <= {out_q[6:0], 1'b0};
            end
            oe_q <= !sen_n && out_phase;
        end
    end

    assign bus.wr_stb = wr_q;
    assign bus.rd_stb = rd_q;
    assign bus.addr   = addr_q;
    assign bus.wdata  = wdata_q;
    assign sdout      = sdout_q;
    assign sdout_oe   = oe_q;

endmodule : serial_port

/* File: tb/spi_host_model.sv */
`timescale 1ns/1ps
// Host side of the serial control port; it changes its lines only on falling system clock edges.
module spi_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      sen_n,
    output logic      sdi,
    input  wire logic sdout,
    input  wire logic sdout_oe
);
    import cfg_pkg::*;

    // The serial clock stands low and the port is deselected between frames.
    initial begin
        sclk  = 1'b0;
        sen_n = 1'b1;
        sdi   = 1'b0;
    end

    // Each serial phase lasts four system cycles, twice the two that the port needs for a read.
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // One frame, read flag first and MSB first; read bits are taken just before each rise.
    task automatic frame(input logic rd, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdata,
                         output logic [DATA_W-1:0] rdata);
        logic [15:0] word;
        word  = {rd, addr, wdata};
        rdata = 8'h00;
        sen_n = 1'b0;
        idle(4);
        for (int i = 15; i >= 0; i--) begin
            sdi = word[i];
            idle(4);
            // A bit taken while the output is not enabled is poisoned, so a dead driver cannot pass.
            rdata = {rdata[6:0], sdout_oe ? sdout : 1'bx};
            sclk = 1'b1;
            idle(4);
            sclk = 1'b0;
        end
        idle(4);
        sen_n = 1'b1;
        // The data line moves away from its last bit once deselected, so stale values cannot pass.
        sdi = ~sdi;
        idle(6);
    endtask : frame

    // Reserved bits are cleaned before sending: interface bit 4, power bits 7:6 low and bit 1 high.
    task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        logic [DATA_W-1:0] v;
        logic [DATA_W-1:0] unused;
        v = (addr == OFF_IF_SEL) ? (data & 8'hEF) : (addr == OFF_POWER) ? ((data & 8'h3F) | 8'h02) : data;
        frame(1'b0, addr, v, unused);
    endtask : wr

    // Read frame; the data byte the host sends is ignored by the port.
    task automatic rd(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
        frame(1'b1, addr, 8'h00, data);
    endtask : rd
endmodule : spi_host_model

/* File: tb/adc_output_if_power_config_bench.sv */
`timescale 1ns/1ps
module adc_output_if_power_config_bench;
    import cfg_pkg::*;

    logic              sys_clk;
    logic              reset_n;
    logic              sclk;
    logic              sen_n;
    logic              sdi;
    logic              sdout;
    logic              sdout_oe;
    bit_map_t          if_bit_map;
    if_mode_t          if_mode;
    logic              clkbuf_off;
    logic              refamp_off;
    logic              refsys_off;
    logic              bandgap_off;
    logic              thermal_on;
    logic              channel_a_off;
    int                fail_count;
    int                n_tests;
    int                m_if;
    int                m_pw;
    int                m_mask;
    int                m_map;
    logic [7:0]        lfsr;
    logic [ADDR_W-1:0] offs[$] = '{7'h00, 7'h07, 7'h08, 7'h0D, 7'h05};

    // Free-running 100 MHz system clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    adc_output_if_power_config dut (
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .SCLK(sclk), .SEN_N(sen_n), .SDI(sdi),
        .SDOUT(sdout), .SDOUT_OE(sdout_oe), .IF_BIT_MAP(if_bit_map), .IF_MODE(if_mode),
        .CLKBUF_OFF(clkbuf_off), .REFAMP_OFF(refamp_off), .REFSYS_OFF(refsys_off),
        .BANDGAP_OFF(bandgap_off), .THERMAL_ON(thermal_on), .CHANNEL_A_OFF(channel_a_off)
    );

    spi_host_model host (
        .clk(sys_clk), .sclk(sclk), .sen_n(sen_n), .sdi(sdi), .sdout(sdout), .sdout_oe(sdout_oe)
    );

    // Eight-bit shift register sequence for the random register values.
    function automatic logic [7:0] next_rand(input logic [7:0] s);
        next_rand = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : next_rand

    // Compares one value and reports at once on a mismatch.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Updates the reference model, then sends the same write through the host.
    task automatic mwr(input int a, input int d);
        if (a == 'h13 && d % 2 == 1) begin
            m_map = ((m_if >> 5) != 0) ? (m_if >> 5) : int'(FUSE_BIT_MAP);
        end
        if ((a == 'h13 || a == 0) && d % 2 == 1) begin
            m_if   = 0;
            m_pw   = 2;
            m_mask = 0;
        end
        if (a == 'h07) m_if = d & 'hEF;
        if (a == 'h08) m_pw = (d & 'h3F) | 2;
        if (a == 'h0D) m_mask = d & 'h2E;
        host.wr(a[6:0], d[7:0]);
    endtask : mwr

    // Checks every output against the model and reads back each register but the fuse load one, plus an unmapped one.
    task automatic check_all();
        logic [7:0] r;
        logic [7:0] p;
        logic [7:0] k;
        p = m_pw[7:0];
        k = m_mask[7:0] & {8{p[0]}};
        chk(8'(if_bit_map), 8'(m_map));
        chk(8'(if_mode), 8'((m_if & 8) != 0 ? (m_if & 7) : int'(FUSE_MODE)));
        chk({1'b0, sdout_oe, clkbuf_off, refamp_off, refsys_off, bandgap_off, thermal_on, channel_a_off},
            {2'b00, p[5] | k[3], p[4] | k[2], k[5], k[1], p[3], p[2]});
        foreach (offs[i]) begin
            host.rd(offs[i], r);
            chk(r, 8'(offs[i] == 7 ? m_if : offs[i] == 8 ? m_pw : offs[i] == 'h0D ? m_mask : 0));
        end
    endtask : check_all

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // The run needs about 33k cycles; a hang is cut off at 80k, inside the cycle budget.
    initial begin
        #800000;
        fail_count++;
        wrap_up();
    end

    // Main sequence: reset, bit maps with reload, modes, power bits, reload discard, soft reset.
    initial begin
        reset_n    = 1'b0;
        fail_count = 0;
        n_tests    = 0;
        lfsr       = 8'h40;
        m_if       = 0;
        m_pw       = 2;
        m_mask     = 0;
        m_map      = int'(FUSE_BIT_MAP);
        repeat (8) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check_all();
        // Interface register first, fuse reload right behind it, before any other setting.
        for (int m = 1; m <= 6; m++) begin
            mwr('h07, m << 5);
            check_all();
            mwr('h13, 1);
            check_all();
        end
        // Override bit off and on for every used mode code; unused codes are left alone.
        for (int c = 0; c < 16; c++) begin
            if ((c & 7) inside {2, 6, 7}) continue;
            mwr('h07, c);
            check_all();
        end
        mwr('h0D, 'h2E);
        // Single power bits under a full mask first, then random values under a random mask.
        for (int i = 0; i < 12; i++) begin
            lfsr = next_rand(lfsr);
            if (i == 6) mwr('h0D, lfsr);
            mwr('h08, i < 6 ? (1 << i) : lfsr);
            check_all();
        end
        mwr('h13, 0);
        check_all();
        mwr('h07, 'h49);
        mwr('h13, 1);
        check_all();
        mwr('h08, 'h3D);
        mwr('h07, 'h6B);
        mwr('h00, 1);
        check_all();
        wrap_up();
    end
endmodule : adc_output_if_power_config_bench
